// ==== verilog/pcl_regs.svh ====
// pcl_regs.svh: offsets, field positions, reset values and counts for the program counter block
// assumes: included by its bare name from the package and the design modules
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH
// =====================================================
// register word indices (byte address = index * 4)
`define PCL_IDX_FLAGS_SAV 12'hfe4
`define PCL_IDX_WORK_SAV 12'hfe5
`define PCL_IDX_BANK_SAV 12'hfe6
`define PCL_IDX_PCHL_SAV 12'hfe7
`define PCL_IDX_PTR0L_SAV 12'hfe8
`define PCL_IDX_PTR0H_SAV 12'hfe9
`define PCL_IDX_PTR1L_SAV 12'hfea
`define PCL_IDX_PTR1H_SAV 12'hfeb
`define PCL_IDX_STK_PTR 12'hfed
`define PCL_IDX_TOS_LOW 12'hfee
`define PCL_IDX_TOS_HIGH 12'hfef
`define PCL_IDX_PC_LOW 12'hff0
`define PCL_IDX_PC_HIGH_LATCH 12'hff1
`define PCL_IDX_WORK 12'hff2
`define PCL_IDX_OP 12'hff3
`define PCL_IDX_PC_FULL 12'hff4
// =====================================================
// field widths and positions
`define PCL_PC_W 15
`define PCL_LOW_W 8
`define PCL_HIGH_W 7
`define PCL_CALL_LOW_W 11
`define PCL_CALL_HI_MSB 6
`define PCL_CALL_HI_LSB 3
`define PCL_STK_DEPTH 16
`define PCL_STK_PTR_W 5
`define PCL_SAVE_COUNT 8
// =====================================================
// reset values
`define PCL_PC_RESET 15'h0000
`define PCL_STK_PTR_RESET 5'h1f
`define PCL_BYTE_RESET 8'h00
`endif

// ==== verilog/pcl_pkg.sv ====
// pcl_pkg.sv: types shared by the program counter block
// assumes: pcl_regs.svh is on the include path
`include "pcl_regs.svh"
package pcl_pkg;
  // =====================================================
  // instruction actions on the counter
  typedef enum logic [2:0] {
    PCL_OP_NONE, PCL_OP_FETCH, PCL_OP_WRITE_LOW, PCL_OP_CALL, PCL_OP_CALL_COMPUTED,
    PCL_OP_BRANCH_REG, PCL_OP_BRANCH_IMM, PCL_OP_RETURN
  } pcl_op_t;
  typedef struct packed {
    pcl_op_t op;
    logic [`PCL_CALL_LOW_W-1:0] operand;
  } pcl_cmd_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
  } pcl_bus_req_t;
endpackage

// ==== verilog/pcl_stack_mem.sv ====
// pcl_stack_mem.sv: return stack storage, one write and one registered read port
// assumes: single clock, write and read addresses in range
`include "pcl_regs.svh"
module pcl_stack_mem
  import pcl_pkg::*;
#(
  parameter int DEPTH = `PCL_STK_DEPTH,
  parameter int WIDTH = `PCL_PC_W,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  always_comb begin
    next_rdata = mem[raddr];
    // a push and a read of the same slot in one cycle hand the pushed word on
    if (we && waddr == raddr) begin
      next_rdata = wdata;
    end
  end

  // storage is not reset; contents are undefined until pushed
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= next_rdata;
  end
endmodule

// ==== verilog/pcl_save_regs.sv ====
// pcl_save_regs.sv: eight byte-wide saved-context copies, software read/write
// assumes: caller gives a read slot, a write slot and a write strobe
`include "pcl_regs.svh"
module pcl_save_regs
  import pcl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [2:0] idx,
  input wire logic [2:0] widx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] save [`PCL_SAVE_COUNT];
  logic [7:0] next_save [`PCL_SAVE_COUNT];
  logic [7:0] next_rdata;

  always_comb begin
    next_save = save;
    if (we) begin
      next_save[widx] = wdata;
    end
    next_rdata = save[idx];
    // a read looked up while that slot is written sees the new byte
    if (we && widx == idx) begin
      next_rdata = wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PCL_SAVE_COUNT; i++) begin
        save[i] <= `PCL_BYTE_RESET;
      end
      rdata <= `PCL_BYTE_RESET;
    end else begin
      save <= next_save;
      rdata <= next_rdata;
    end
  end
endmodule

// ==== verilog/pcl_core.sv ====
// pcl_core.sv: program counter with low-byte register, high latch, return stack and
// saved-context registers, reached over an AHB-Lite slave
// assumes: one clock, core drives one instruction command per cycle on CMD
`include "pcl_regs.svh"
module pcl_core
  import pcl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire pcl_cmd_t CMD,
  input wire logic [7:0] CMD_LOW_DATA,
  input wire logic [7:0] CMD_IMM_OFFSET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [`PCL_PC_W-1:0] PC_OUT,
  output logic STACK_OVERFLOW,
  output logic STACK_UNDERFLOW
);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int SAW = 4;

  // =====================================================
  // state
  logic [`PCL_PC_W-1:0] pc, next_pc;
  logic [`PCL_HIGH_W-1:0] pch_latch, next_pch_latch;
  logic [7:0] work, next_work;
  logic [`PCL_STK_PTR_W-1:0] stk_ptr, next_stk_ptr;
  logic ovf, next_ovf, unf, next_unf;
  logic [31:0] rdata, next_rdata;
  pcl_bus_req_t req, next_req;
  logic req_valid, next_req_valid;
  logic read_pending, next_read_pending;

  logic stk_we;
  logic [SAW-1:0] stk_waddr;
  logic [`PCL_PC_W-1:0] stk_wdata;
  logic [`PCL_PC_W-1:0] tos;
  logic save_we;
  logic [2:0] save_widx;
  logic [2:0] save_ridx;
  logic [7:0] save_rdata;

  // =====================================================
  // helpers
  function automatic logic [11:0] word_index(input logic [31:0] a);
    return a[13:2];
  endfunction

  function automatic logic [`PCL_PC_W-1:0] join_pc(input logic [`PCL_HIGH_W-1:0] hi,
                                                   input logic [7:0] lo);
    return {hi, lo};
  endfunction

  function automatic logic [`PCL_PC_W-1:0] pc_add(input logic [`PCL_PC_W-1:0] a,
                                                  input logic [`PCL_PC_W-1:0] b);
    return `PCL_PC_W'(a + b);
  endfunction

  function automatic logic in_save(input logic [11:0] i);
    return i >= `PCL_IDX_FLAGS_SAV && i <= `PCL_IDX_PTR1H_SAV;
  endfunction

  function automatic logic [2:0] save_slot(input logic [11:0] i);
    return 3'(i - `PCL_IDX_FLAGS_SAV);
  endfunction

  // =====================================================
  // bus slave: address phase captured, data phase acted on next cycle
  logic [11:0] idx;
  logic bus_wr, bus_rd;
  logic [7:0] wbyte;
  logic wr_low, wr_latch;

  always_comb begin
    next_req = req;
    next_req_valid = 1'b0;
    if (HSEL && HREADY && HTRANS == HTRANS_NONSEQ) begin
      next_req.addr = HADDR;
      next_req.write = HWRITE;
      next_req_valid = 1'b1;
    end
    idx = word_index(req.addr);
    bus_wr = req_valid && req.write;
    bus_rd = req_valid && !req.write;
    wbyte = HWDATA[7:0];
    wr_low = bus_wr && idx == `PCL_IDX_PC_LOW;
    wr_latch = bus_wr && idx == `PCL_IDX_PC_HIGH_LATCH;
    save_we = bus_wr && in_save(idx);
    // writes land in the data phase, reads are looked up in the address phase;
    // separate slots keep a read right behind a save write on its own word
    save_widx = save_slot(idx);
    save_ridx = save_slot(word_index(next_req.addr));
    next_read_pending = next_req_valid && !HWRITE;
  end

  // =====================================================
  // counter, latch, accumulator and stack pointer
  always_comb begin
    next_pc = pc;
    next_pch_latch = pch_latch;
    next_work = work;
    next_stk_ptr = stk_ptr;
    next_ovf = ovf;
    next_unf = unf;
    stk_we = 1'b0;
    stk_waddr = stk_ptr[SAW-1:0];
    stk_wdata = pc;
    if (wr_latch) begin
      next_pch_latch = wbyte[`PCL_HIGH_W-1:0];
    end
    if (bus_wr && idx == `PCL_IDX_WORK) begin
      next_work = wbyte;
    end
    if (bus_wr && idx == `PCL_IDX_STK_PTR) begin
      next_stk_ptr = wbyte[`PCL_STK_PTR_W-1:0];
    end
    if (bus_wr && idx == `PCL_IDX_TOS_LOW) begin
      stk_we = 1'b1;
      stk_wdata = {tos[`PCL_PC_W-1:8], wbyte};
    end
    if (bus_wr && idx == `PCL_IDX_TOS_HIGH) begin
      stk_we = 1'b1;
      stk_wdata = {wbyte[`PCL_HIGH_W-1:0], tos[7:0]};
    end
    if (wr_low) begin
      // upper bits only ever from the latch
      next_pc = join_pc(pch_latch, wbyte);
    end else begin
      unique case (CMD.op)
        PCL_OP_NONE: begin
        end
        PCL_OP_FETCH: begin
          next_pc = pc_add(pc, `PCL_PC_W'(1));
        end
        PCL_OP_WRITE_LOW: begin
          next_pc = join_pc(pch_latch, CMD_LOW_DATA);
        end
        PCL_OP_CALL, PCL_OP_CALL_COMPUTED: begin
          // push the return address, then jump; past sixteen levels the oldest
          // slot is overwritten and only the sticky flag tells
          next_stk_ptr = `PCL_STK_PTR_W'(stk_ptr + 1'b1);
          if (stk_ptr == `PCL_STK_PTR_W'(`PCL_STK_DEPTH - 1)) begin
            next_ovf = 1'b1;
          end
          stk_we = 1'b1;
          stk_waddr = next_stk_ptr[SAW-1:0];
          stk_wdata = pc_add(pc, `PCL_PC_W'(1));
          if (CMD.op == PCL_OP_CALL) begin
            next_pc = {pch_latch[`PCL_CALL_HI_MSB:`PCL_CALL_HI_LSB], CMD.operand};
          end else begin
            next_pc = join_pc(pch_latch, work);
          end
        end
        PCL_OP_BRANCH_REG: begin
          next_pc = pc_add(pc_add(pc, `PCL_PC_W'(1)), {7'h00, work});
        end
        PCL_OP_BRANCH_IMM: begin
          next_pc = pc_add(pc_add(pc, `PCL_PC_W'(1)), {{7{CMD_IMM_OFFSET[7]}}, CMD_IMM_OFFSET});
        end
        PCL_OP_RETURN: begin
          // tos already follows the pointer, so the pop needs no extra cycle
          next_pc = tos;
          if (stk_ptr == `PCL_STK_PTR_RESET) begin
            next_unf = 1'b1;
          end
          next_stk_ptr = `PCL_STK_PTR_W'(stk_ptr - 1'b1);
        end
      endcase
    end
  end

  // =====================================================
  // read data, assembled in the data phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (read_pending) begin
      unique case (idx)
        `PCL_IDX_PC_LOW: next_rdata = {24'h000000, pc[7:0]};
        `PCL_IDX_PC_HIGH_LATCH: next_rdata = {25'h0000000, pch_latch};
        `PCL_IDX_WORK: next_rdata = {24'h000000, work};
        `PCL_IDX_STK_PTR: next_rdata = {27'h0000000, stk_ptr};
        `PCL_IDX_TOS_LOW: next_rdata = {24'h000000, tos[7:0]};
        `PCL_IDX_TOS_HIGH: next_rdata = {25'h0000000, tos[`PCL_PC_W-1:8]};
        `PCL_IDX_PC_FULL: next_rdata = {17'h00000, pc};
        default: begin
          if (in_save(idx)) begin
            next_rdata = {24'h000000, save_rdata};
          end
        end
      endcase
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pc <= `PCL_PC_RESET;
      pch_latch <= 7'h00;
      work <= `PCL_BYTE_RESET;
      stk_ptr <= `PCL_STK_PTR_RESET;
      ovf <= 1'b0;
      unf <= 1'b0;
      req <= '0;
      req_valid <= 1'b0;
      read_pending <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      pc <= next_pc;
      pch_latch <= next_pch_latch;
      work <= next_work;
      stk_ptr <= next_stk_ptr;
      ovf <= next_ovf;
      unf <= next_unf;
      req <= next_req;
      req_valid <= next_req_valid;
      read_pending <= next_read_pending;
      rdata <= next_rdata;
    end
  end

  // outputs straight from flops
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      PC_OUT <= `PCL_PC_RESET;
      STACK_OVERFLOW <= 1'b0;
      STACK_UNDERFLOW <= 1'b0;
    end else begin
      // a read waits one extra cycle so save-register and stack data can settle
      HREADYOUT <= !(next_read_pending);
      HRDATA <= next_rdata;
      HRESP <= 1'b0;
      PC_OUT <= next_pc;
      STACK_OVERFLOW <= next_ovf;
      STACK_UNDERFLOW <= next_unf;
    end
  end

  // =====================================================
  // storage
  pcl_stack_mem #(
    .DEPTH(`PCL_STK_DEPTH),
    .WIDTH(`PCL_PC_W),
    .AW(SAW)
  ) u_stack (
    .clk(REF_CLK),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(next_stk_ptr[SAW-1:0]),
    .rdata(tos)
  );

  pcl_save_regs u_save (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .we(save_we),
    .idx(save_ridx),
    .widx(save_widx),
    .wdata(wbyte),
    .rdata(save_rdata)
  );
endmodule

// ==== tb/pcl_core_sva.sv ====
// pcl_core_sva.sv: concurrent checks on the program counter ports
// assumes: bound to pcl_core; bus writes act at the edge that ends the data phase
`include "pcl_regs.svh"
module pcl_core_sva
  import pcl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire pcl_cmd_t CMD,
  input wire logic [7:0] CMD_LOW_DATA,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [`PCL_PC_W-1:0] PC_OUT
);
  // ==========================================
  // shadow of latch and accumulator, so the checks need no peeking
  logic pend;
  logic [11:0] pidx;
  logic [6:0] lat;
  logic [7:0] acc;
  logic wlow;
  assign wlow = pend && pidx == `PCL_IDX_PC_LOW;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend <= 1'b0;
      pidx <= 12'h000;
      lat <= 7'h00;
      acc <= 8'h00;
    end else begin
      pend <= HSEL && HREADY && HTRANS == 2'b10 && HWRITE;
      pidx <= HADDR[13:2];
      if (pend && pidx == `PCL_IDX_PC_HIGH_LATCH) lat <= HWDATA[6:0];
      if (pend && pidx == `PCL_IDX_WORK) acc <= HWDATA[7:0];
    end
  end
  // ==========================================
  // checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // a bus write to the low byte wins over the command
  sequence s_cmd(pcl_op_t o);
    CMD.op == o && !wlow;
  endsequence
  a_reset_clears: assert property ($fell(SYS_RST) |-> PC_OUT == 15'h0000)
    else $error("counter not zero after reset");
  a_fetch_step: assert property (
    s_cmd(PCL_OP_FETCH) |=> PC_OUT == 15'($past(PC_OUT) + 15'h0001))
    else $error("fetch did not advance by one");
  a_idle_hold: assert property (s_cmd(PCL_OP_NONE) |=> $stable(PC_OUT))
    else $error("counter moved while idle");
  a_bus_low: assert property (wlow |=> PC_OUT == {lat, $past(HWDATA[7:0])})
    else $error("bus low write did not load latch and byte");
  a_instr_low: assert property (
    s_cmd(PCL_OP_WRITE_LOW) |=> PC_OUT == {$past(lat), $past(CMD_LOW_DATA)})
    else $error("instruction low write wrong");
  a_abs_call: assert property (
    s_cmd(PCL_OP_CALL) |=> PC_OUT == {$past(lat[6:3]), $past(CMD.operand)})
    else $error("absolute call target wrong");
  a_comp_call: assert property (
    s_cmd(PCL_OP_CALL_COMPUTED) |=> PC_OUT == {$past(lat), $past(acc)})
    else $error("computed call target wrong");
  a_reg_branch: assert property (
    s_cmd(PCL_OP_BRANCH_REG) |=> PC_OUT == 15'($past(PC_OUT) + 15'h0001 + {7'h00, $past(acc)}))
    else $error("register branch target wrong");
endmodule
bind pcl_core pcl_core_sva pcl_core_sva_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD(CMD),
  .CMD_LOW_DATA(CMD_LOW_DATA), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .PC_OUT(PC_OUT));

// ==== tb/tb_pcl_core.sv ====
// tb_pcl_core.sv: self-checking bench with an integer model of the counter
// assumes: single AHB-Lite master, hready is the block's own hreadyout
module tb_pcl_core
  import pcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  pcl_cmd_t CMD;
  logic [7:0] CMD_LOW_DATA, CMD_IMM_OFFSET;
  logic HSEL, HWRITE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic HREADYOUT, HRESP;
  logic STACK_OVERFLOW, STACK_UNDERFLOW;
  wire logic HREADY;
  logic [14:0] PC_OUT;
  int miscompares = 0;
  int checks_done = 0;
  assign HREADY = HREADYOUT;
  pcl_core pcl_core_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD(CMD),
    .CMD_LOW_DATA(CMD_LOW_DATA), .CMD_IMM_OFFSET(CMD_IMM_OFFSET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PC_OUT(PC_OUT),
    .STACK_OVERFLOW(STACK_OVERFLOW), .STACK_UNDERFLOW(STACK_UNDERFLOW));
  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  // ==========================================
  // verdict, compares and drivers
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_pc(input int e);
    checks_done++;
    if (PC_OUT !== 15'(e)) begin
      miscompares++;
      $display("BAD PC_OUT exp %h got %h", 15'(e), PC_OUT);
    end
  endtask
  task automatic chk_rd(input logic [11:0] idx, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD reg %h exp %h got %h", idx, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  // entered just after a rising edge; waits are bounded
  task automatic ahb(input logic w, input logic [11:0] idx, input int d, output logic [31:0] rd);
    int n;
    n = 0;
    HSEL <= 1'b1;
    HADDR <= {18'h00000, idx, 2'b00};
    HTRANS <= 2'b10;
    HWRITE <= w;
    do begin @(posedge REF_CLK); n++; end while (HREADY !== 1'b1 && n < 40);
    HTRANS <= 2'b00;
    HSEL <= 1'b0;
    HWDATA <= 32'(d);
    do begin @(posedge REF_CLK); n++; end while (HREADY !== 1'b1 && n < 40);
    rd = HRDATA;
    chk_flag("HRESP", 1'b0, HRESP);
    if (n >= 40) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic run(input pcl_op_t o, input int opd);
    CMD <= '{o, 11'(opd)};
    CMD_LOW_DATA <= 8'($urandom);
    @(posedge REF_CLK);
    CMD <= '{PCL_OP_NONE, 11'h000};
    @(posedge REF_CLK);
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] rd;
    int pc, lat, acc, b, r;
    int stk[$];
    CMD = '{PCL_OP_NONE, 11'h000};
    CMD_LOW_DATA = 8'h00;
    CMD_IMM_OFFSET = 8'h00;
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    HSIZE = 3'b010;
    repeat (12) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    void'($urandom(37));
    @(posedge REF_CLK);
    chk_pc(0);
    for (int i = 0; i < 10; i++) begin
      ahb(0, 12'hfe4 + 12'(i), 0, rd);
      chk_rd(12'hfe4 + 12'(i), (i == 9) ? 32'h1f : 32'h0, rd);
      r = $urandom & 8'hff;
      ahb(1, 12'hfe4 + 12'(i), r, rd);
      ahb(0, 12'hfe4 + 12'(i), 0, rd);
      chk_rd(12'hfe4 + 12'(i), (i < 8) ? r : (i == 9) ? r & 8'h1f : 0, rd);
    end
    ahb(1, 12'hfed, 32'h1f, rd);
    ahb(1, 12'h100, 8'h5a, rd);
    ahb(0, 12'h100, 0, rd);
    chk_rd(12'h100, 0, rd);
    for (int k = 0; k < 4; k++) begin
      lat = $urandom & 8'h7f;
      acc = $urandom & 8'hff;
      b = $urandom & 8'hff;
      CMD_IMM_OFFSET <= 8'($urandom);
      ahb(1, 12'hff1, lat, rd);
      ahb(1, 12'hff2, acc, rd);
      ahb(1, 12'hff0, b, rd);
      @(posedge REF_CLK);
      pc = (lat << 8) | b;
      chk_pc(pc);
      ahb(0, 12'hff0, 0, rd);
      chk_rd(12'hff0, b, rd);
      run(PCL_OP_FETCH, 0);
      pc = (pc + 1) & 15'h7fff;
      chk_pc(pc);
      run(PCL_OP_WRITE_LOW, 0);
      pc = (lat << 8) | CMD_LOW_DATA;
      chk_pc(pc);
      r = $urandom & 11'h7ff;
      stk.push_back((pc + 1) & 15'h7fff);
      run(PCL_OP_CALL, r);
      pc = ((lat >> 3) << 11) | r;
      chk_pc(pc);
      stk.push_back((pc + 1) & 15'h7fff);
      run(PCL_OP_CALL_COMPUTED, 0);
      pc = (lat << 8) | acc;
      chk_pc(pc);
      run(PCL_OP_BRANCH_REG, 0);
      pc = (pc + 1 + acc) & 15'h7fff;
      chk_pc(pc);
      run(PCL_OP_BRANCH_IMM, 0);
      pc = (pc + 1 + int'($signed(CMD_IMM_OFFSET))) & 15'h7fff;
      chk_pc(pc);
      run(PCL_OP_RETURN, 0);
      pc = stk.pop_back();
      chk_pc(pc);
    end
    ahb(0, 12'hfee, 0, rd);
    chk_rd(12'hfee, stk[$] & 8'hff, rd);
    ahb(0, 12'hfef, 0, rd);
    chk_rd(12'hfef, stk[$] >> 8, rd);
    while (stk.size() > 0) begin
      run(PCL_OP_RETURN, 0);
      pc = stk.pop_back();
      chk_pc(pc);
    end
    chk_flag("STACK_UNDERFLOW", 1'b0, STACK_UNDERFLOW);
    for (int j = 0; j < 17; j++) begin
      chk_flag("STACK_OVERFLOW", 1'b0, STACK_OVERFLOW);
      run(PCL_OP_CALL, j);
      chk_pc(((lat >> 3) << 11) | j);
    end
    chk_flag("STACK_OVERFLOW", 1'b1, STACK_OVERFLOW);
    ahb(1, 12'hfed, 32'h1f, rd);
    run(PCL_OP_RETURN, 0);
    chk_flag("STACK_UNDERFLOW", 1'b1, STACK_UNDERFLOW);
    ahb(1, 12'hff1, 8'h7f, rd);
    ahb(1, 12'hff0, 8'hff, rd);
    @(posedge REF_CLK);
    chk_pc(15'h7fff);
    run(PCL_OP_FETCH, 0);
    chk_pc(0);
    run(PCL_OP_FETCH, 0);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    chk_pc(0);
    chk_flag("STACK_OVERFLOW", 1'b0, STACK_OVERFLOW);
    chk_flag("STACK_UNDERFLOW", 1'b0, STACK_UNDERFLOW);
    wrap_up();
  end
endmodule
